// ==== flb_bus_cycle.sv ====
// Purpose: Performs one asynchronous flash write or read cycle on the pins.
// Assumes: Start is only raised while the engine is idle.
// Notes: All pin outputs come from flip-flops; done is a one-cycle pulse.
`default_nettype none

module flb_bus_cycle (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Request
  input wire logic start,
  input wire logic isRead,
  input wire logic [21:0] addr,
  input wire logic [15:0] data,
  // Answer
  output logic done,
  output logic [15:0] rdData,
  // Flash pins
  output flb_pkg::flb_pins_type pins,
  input wire logic [15:0] dqIn
);

  typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} flb_cycle_type;

  flb_cycle_type state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic rd_reg, rd_next;
  logic done_reg, done_next;
  logic [15:0] rdData_reg, rdData_next;
  flb_pkg::flb_pins_type pins_reg, pins_next;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    rdData_next = rdData_reg;
    pins_next = pins_reg;
    case (state_reg)
      CY_IDLE:
      begin
        if (start)
        begin
          rd_next = isRead;
          pins_next.addr = addr;
          pins_next.dqOut = data;
          pins_next.dqOe = !isRead;
          pins_next.ceN = 1'b0;
          state_next = CY_SETUP;
        end
      end
      CY_SETUP:
      begin
        pins_next.weN = rd_reg;
        pins_next.oeN = !rd_reg;
        cnt_next = rd_reg ? flb_pkg::READ_CNT : flb_pkg::STROBE_CNT;
        state_next = CY_STROBE;
      end
      CY_STROBE:
      begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1)
        begin
          // Sampling on the last low cycle gives the full access time.
          if (rd_reg)
          begin
            rdData_next = dqIn;
          end
          pins_next.weN = 1'b1;
          pins_next.oeN = 1'b1;
          state_next = CY_HOLD;
        end
      end
      CY_HOLD:
      begin
        pins_next.ceN = 1'b1;
        pins_next.dqOe = 1'b0;
        done_next = 1'b1;
        state_next = CY_IDLE;
      end
      default:
      begin
        state_next = CY_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= CY_IDLE;
      cnt_reg <= 4'h0;
      rd_reg <= 1'b0;
      done_reg <= 1'b0;
      rdData_reg <= 16'h0000;
      pins_reg <= '{addr: 22'h000000, dqOut: 16'h0000, dqOe: 1'b0,
                    ceN: 1'b1, weN: 1'b1, oeN: 1'b1};
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rd_reg <= rd_next;
      done_reg <= done_next;
      rdData_reg <= rdData_next;
      pins_reg <= pins_next;
    end
  end

  assign done = done_reg;
  assign rdData = rdData_reg;
  assign pins = pins_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence writePulse;
    (pins.weN == 1'b0) [*2] ##1 (pins.weN == 1'b1);
  endsequence

  a_write_pulse_len: assert property ($fell(pins.weN) |-> writePulse)
    else $error("write strobe not held for its full width");
  a_write_drives_dq: assert property (!pins.weN |-> pins.dqOe && !pins.ceN && pins.oeN)
    else $error("write strobe without data drive or chip enable");

endmodule // flb_bus_cycle

`default_nettype wire

// ==== flb_flash_model.sv ====
// Purpose: Behavioural flash device answering the controller's pins.
// Assumes: Four blocks picked by address bits 17:16; status always ready.
// Notes: Released data lines show the inverse of the last driven word.
`default_nettype none
module flb_flash_model (
  // Pins
  input wire logic clk,
  input wire flb_pkg::flb_pins_type pins,
  input wire logic rstN,
  input wire logic protectN,
  output logic [15:0] dqIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lk [4];
  logic [1:0] lkv;
  logic [15:0] sw, val, lastVal, d;
  logic [15:0] otpLock = 16'hfffe;
  logic idMode, lockSetup, otpSetup, weLast, drive;
  logic [1:0] blk;
  assign blk = pins.addr[17:16];
  assign d = pins.dqOut;
  assign drive = !pins.oeN && !pins.ceN;
  // With protect low a locked-down block reads locked again, whatever was done meanwhile.
  assign lkv = {lk[blk][1], lk[blk][0] | (lk[blk][1] & !protectN)};
  assign val = !idMode ? sw : pins.addr[7] ? otpLock : {14'h0, lkv};
  assign dqIn = drive ? val : ~lastVal;
  // Lock state is lost on reset but the protection lockout is not.
  always @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      lk <= '{default: 2'h1};
      sw <= 16'h0080;
      {idMode, lockSetup, otpSetup, weLast} <= 4'h1;
    end
    else
    begin
      weLast <= pins.weN;
      if (drive)
        lastVal <= val;
      if (pins.weN && !weLast && !pins.ceN)
      begin
        lockSetup <= 1'b0;
        otpSetup <= 1'b0;
        if (lockSetup)
        begin
          if (sw[2])
            lk[blk] <= lk[blk];
          else if (d == flb_pkg::FC_LOCK)
            lk[blk][0] <= 1'b1;
          else if (d == flb_pkg::FC_UNLOCK && !(lk[blk][1] && !protectN))
            lk[blk][0] <= 1'b0;
          else if (d == flb_pkg::FC_LOCKDOWN)
            lk[blk] <= 2'h3;
          else
            sw <= sw | 16'h0030;
        end
        else if (otpSetup)
        begin
          if (!otpLock[1])
            sw <= sw | 16'h0012;
          else if (pins.addr == flb_pkg::OTP_FIRST)
            otpLock <= otpLock & d;
        end
        else if (d == flb_pkg::FC_LOCK_SETUP)
          lockSetup <= 1'b1;
        else if (d == flb_pkg::FC_OTP_SETUP)
          otpSetup <= 1'b1;
        else if (d == flb_pkg::FC_READ_IDENT || d == flb_pkg::FC_READ_ARRAY)
          idMode <= d == flb_pkg::FC_READ_IDENT;
        else if (d == flb_pkg::FC_SUSPEND || d == flb_pkg::FC_RESUME)
          sw[6] <= d == flb_pkg::FC_SUSPEND;
        else if (d == flb_pkg::FC_CLEAR_STATUS)
          sw <= 16'h0080;
      end
    end
  end
endmodule // flb_flash_model
`default_nettype wire

// ==== flb_lock_ctrl.sv ====
// Purpose: Host controller that scripts lock, identifier and protection commands.
// Assumes: Flash pins are sampled synchronously; software uses the plain port.
// Notes: One operation runs at a time; commands written while busy are dropped without setting the refused flag.
`default_nettype none

module flb_lock_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Software register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Flash pins
  output flb_pkg::flb_pins_type flashPins,
  input wire logic [15:0] flashDqIn,
  output logic flashRstN,
  output logic flashProtectN
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release.
  logic [1:0] rstPipe_reg;
  logic rstSync;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstPipe_reg <= 2'h0;
    end
    else
    begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end

  assign rstSync = rstPipe_reg[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Operation scripts.
  function automatic flb_pkg::flb_step_type stepOf(input logic [3:0] op, input logic [1:0] idx);
    flb_pkg::flb_step_type s;
    s = '{kind: flb_pkg::SK_END, addrPlus2: 1'b0, useData: 1'b0, code: 16'h0000};
    case (op)
      flb_pkg::OP_LOCK, flb_pkg::OP_UNLOCK, flb_pkg::OP_LOCKDOWN:
      begin
        if (idx == 2'h0)
        begin
          s.kind = flb_pkg::SK_WRITE;
          s.code = flb_pkg::FC_LOCK_SETUP;
        end
        else if (idx == 2'h1)
        begin
          s.kind = flb_pkg::SK_WRITE;
          s.code = (op == flb_pkg::OP_LOCK) ? flb_pkg::FC_LOCK :
                   (op == flb_pkg::OP_UNLOCK) ? flb_pkg::FC_UNLOCK :
                   flb_pkg::FC_LOCKDOWN;
        end
      end
      flb_pkg::OP_LOCK_READ, flb_pkg::OP_OTP_READ:
      begin
        if (idx == 2'h0)
        begin
          s.kind = flb_pkg::SK_WRITE;
          s.code = flb_pkg::FC_READ_IDENT;
        end
        else if (idx == 2'h1)
        begin
          s.kind = flb_pkg::SK_READ;
          s.addrPlus2 = (op == flb_pkg::OP_LOCK_READ);
        end
        else if (idx == 2'h2)
        begin
          s.kind = flb_pkg::SK_WRITE;
          s.code = flb_pkg::FC_READ_ARRAY;
        end
      end
      flb_pkg::OP_OTP_PROG, flb_pkg::OP_OTP_LOCK:
      begin
        if (idx == 2'h0)
        begin
          s.kind = flb_pkg::SK_WRITE;
          s.code = flb_pkg::FC_OTP_SETUP;
        end
        else if (idx == 2'h1)
        begin
          s.kind = flb_pkg::SK_WRITE;
          s.useData = (op == flb_pkg::OP_OTP_PROG);
          s.code = flb_pkg::OTP_LOCK_VALUE;
        end
        else if (idx == 2'h2)
        begin
          s.kind = flb_pkg::SK_POLL;
        end
        else
        begin
          s.kind = flb_pkg::SK_WRITE;
          s.code = flb_pkg::FC_READ_ARRAY;
        end
      end
      flb_pkg::OP_SUSPEND, flb_pkg::OP_STATUS:
      begin
        if (idx == 2'h0)
        begin
          s.kind = flb_pkg::SK_WRITE;
          s.code = (op == flb_pkg::OP_SUSPEND) ? flb_pkg::FC_SUSPEND :
                   flb_pkg::FC_READ_STATUS;
        end
        else if (idx == 2'h1)
        begin
          s.kind = flb_pkg::SK_POLL;
        end
      end
      flb_pkg::OP_RESUME, flb_pkg::OP_CLEAR:
      begin
        if (idx == 2'h0)
        begin
          s.kind = flb_pkg::SK_WRITE;
          s.code = (op == flb_pkg::OP_RESUME) ? flb_pkg::FC_RESUME :
                   flb_pkg::FC_CLEAR_STATUS;
        end
      end
      default:
      begin
        s.kind = flb_pkg::SK_END;
      end
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer and registers.
  typedef enum logic [1:0] {SQ_IDLE, SQ_START, SQ_WAIT} flb_seq_type;

  flb_seq_type state_reg, state_next;
  logic [3:0] op_reg, op_next;
  logic [1:0] idx_reg, idx_next;
  logic [11:0] poll_reg, poll_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic [21:0] addr_reg, addr_next;
  logic [15:0] data_reg, data_next;
  logic [15:0] result_reg, result_next;
  logic [7:0] status_reg, status_next;
  logic refused_reg, refused_next;
  logic timeout_reg, timeout_next;
  logic suspended_reg, suspended_next;
  logic [31:0] rdData_reg, rdData_next;
  flb_pkg::flb_step_type step;
  logic engStart, engRead, engDone;
  logic [21:0] engAddr;
  logic [15:0] engData, engRdData;
  logic cmdWrite, otpOp, rangeOk, lockOp;

  assign step = stepOf(op_reg, idx_reg);
  assign engStart = (state_reg == SQ_START) && (step.kind != flb_pkg::SK_END);
  assign engRead = (step.kind == flb_pkg::SK_READ) || (step.kind == flb_pkg::SK_POLL);
  assign engAddr = step.addrPlus2 ? addr_reg + flb_pkg::LOCK_STATUS_OFS : addr_reg;
  assign engData = step.useData ? data_reg : step.code;
  assign cmdWrite = regWr && (regAddr == flb_pkg::REG_CMD);
  assign otpOp = (regWrData[3:0] == flb_pkg::OP_OTP_PROG) ||
                 (regWrData[3:0] == flb_pkg::OP_OTP_LOCK);
  assign rangeOk = (addr_reg >= flb_pkg::OTP_FIRST) && (addr_reg <= flb_pkg::OTP_LAST);
  assign lockOp = (regWrData[3:0] >= flb_pkg::OP_LOCK) &&
                  (regWrData[3:0] <= flb_pkg::OP_LOCKDOWN);

  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    idx_next = idx_reg;
    poll_next = poll_reg;
    status_next = status_reg;
    result_next = result_reg;
    refused_next = refused_reg;
    timeout_next = timeout_reg;
    suspended_next = suspended_reg;
    case (state_reg)
      SQ_IDLE:
      begin
        if (cmdWrite)
        begin
          // Out-of-window protection writes are refused and never reach the device.
          if (regWrData[3:0] == 4'h0 || regWrData[3:0] > flb_pkg::OP_LAST ||
              (otpOp && !rangeOk) || !ctrl_reg[flb_pkg::CTRL_RUN])
          begin
            refused_next = 1'b1;
          end
          else
          begin
            op_next = regWrData[3:0];
            idx_next = 2'h0;
            poll_next = 12'h000;
            refused_next = 1'b0;
            timeout_next = 1'b0;
            state_next = SQ_START;
            // Locking keeps a suspended erase suspended until resume is sent.
            if (lockOp && suspended_reg)
            begin
              suspended_next = 1'b1;
            end
          end
        end
      end
      SQ_START:
      begin
        state_next = (step.kind == flb_pkg::SK_END) ? SQ_IDLE : SQ_WAIT;
        if (step.kind == flb_pkg::SK_END && op_reg == flb_pkg::OP_RESUME)
        begin
          suspended_next = 1'b0;
        end
      end
      SQ_WAIT:
      begin
        if (engDone)
        begin
          // Four-step scripts end here, because the step index would wrap to the first step.
          state_next = (idx_reg == 2'h3) ? SQ_IDLE : SQ_START;
          idx_next = idx_reg + 2'h1;
          if (step.kind == flb_pkg::SK_READ)
          begin
            result_next = engRdData;
          end
          else if (step.kind == flb_pkg::SK_POLL)
          begin
            status_next = engRdData[7:0];
            if (!engRdData[flb_pkg::SW_READY] && poll_reg != flb_pkg::POLL_LIMIT)
            begin
              poll_next = poll_reg + 12'h001;
              idx_next = idx_reg;
            end
            else
            begin
              timeout_next = !engRdData[flb_pkg::SW_READY];
              if (op_reg == flb_pkg::OP_SUSPEND)
              begin
                suspended_next = engRdData[flb_pkg::SW_ERASE_SUSP];
              end
            end
          end
        end
      end
      default:
      begin
        state_next = SQ_IDLE;
      end
    endcase
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    rdData_next = 32'h00000000;
    if (regWr && regAddr == flb_pkg::REG_CTRL)
    begin
      ctrl_next = regWrData[1:0];
    end
    if (regWr && regAddr == flb_pkg::REG_ADDR && state_reg == SQ_IDLE)
    begin
      addr_next = regWrData[21:0];
    end
    if (regWr && regAddr == flb_pkg::REG_DATA && state_reg == SQ_IDLE)
    begin
      data_next = regWrData[15:0];
    end
    if (regRd)
    begin
      case (regAddr)
        flb_pkg::REG_CTRL: rdData_next = {30'h00000000, ctrl_reg};
        flb_pkg::REG_CMD: rdData_next = {28'h0000000, op_reg};
        flb_pkg::REG_ADDR: rdData_next = {10'h000, addr_reg};
        flb_pkg::REG_DATA: rdData_next = {16'h0000, data_reg};
        flb_pkg::REG_STATUS:
        begin
          rdData_next = {16'h0000, status_reg, 1'b0,
                         status_reg[flb_pkg::SW_SUPPLY_ERR],
            status_reg[flb_pkg::SW_PROG_ERR] & status_reg[flb_pkg::SW_LOCK_ERR],
            status_reg[flb_pkg::SW_PROG_ERR] & status_reg[flb_pkg::SW_ERASE_ERR],
                         suspended_reg, timeout_reg, refused_reg, state_reg != SQ_IDLE};
        end
        flb_pkg::REG_RESULT:
        begin
          rdData_next = (op_reg == flb_pkg::OP_LOCK_READ) ?
                        {30'h00000000, result_reg[1:0]} : {16'h0000, result_reg};
        end
        default: rdData_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      state_reg <= SQ_IDLE;
      op_reg <= 4'h0;
      idx_reg <= 2'h0;
      poll_reg <= 12'h000;
      ctrl_reg <= flb_pkg::CTRL_RESET;
      addr_reg <= 22'h000000;
      data_reg <= 16'h0000;
      result_reg <= 16'h0000;
      status_reg <= 8'h00;
      refused_reg <= 1'b0;
      timeout_reg <= 1'b0;
      suspended_reg <= 1'b0;
      rdData_reg <= 32'h00000000;
      flashRstN <= 1'b0;
      flashProtectN <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      idx_reg <= idx_next;
      poll_reg <= poll_next;
      ctrl_reg <= ctrl_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      result_reg <= result_next;
      status_reg <= status_next;
      refused_reg <= refused_next;
      timeout_reg <= timeout_next;
      suspended_reg <= suspended_next;
      rdData_reg <= rdData_next;
      flashRstN <= ctrl_next[flb_pkg::CTRL_RUN];
      flashProtectN <= ctrl_next[flb_pkg::CTRL_PROTECT_HIGH];
    end
  end

  assign regRdData = rdData_reg;

  flb_bus_cycle u_cycle (
    .clk(clk),
    .nrst(rstSync),
    .start(engStart),
    .isRead(engRead),
    .addr(engAddr),
    .data(engData),
    .done(engDone),
    .rdData(engRdData),
    .pins(flashPins),
    .dqIn(flashDqIn)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the command stream sent to the flash.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstSync);

  logic wrStart;
  assign wrStart = engStart && !engRead;

  sequence setupSent;
    wrStart && engData == flb_pkg::FC_LOCK_SETUP && idx_reg == 2'h0;
  endsequence

  sequence confirmNext(logic [15:0] code);
    ##[1:20] (wrStart && idx_reg == 2'h1 && engData == code);
  endsequence

  a_lock_confirm: assert property (
    setupSent ##0 (op_reg == flb_pkg::OP_LOCK) |-> confirmNext(flb_pkg::FC_LOCK))
    else $error("lock setup not followed by lock confirm");
  a_unlock_confirm: assert property (
    setupSent ##0 (op_reg == flb_pkg::OP_UNLOCK) |-> confirmNext(flb_pkg::FC_UNLOCK))
    else $error("lock setup not followed by unlock confirm");
  a_lockdown_confirm: assert property (
    setupSent ##0 (op_reg == flb_pkg::OP_LOCKDOWN) |-> confirmNext(flb_pkg::FC_LOCKDOWN))
    else $error("lock setup not followed by lock-down confirm");
  a_status_read_addr: assert property (
    engStart && engRead && op_reg == flb_pkg::OP_LOCK_READ |->
    engAddr == addr_reg + flb_pkg::LOCK_STATUS_OFS)
    else $error("lock status read at wrong address");
  a_ident_exit: assert property (
    engDone && op_reg == flb_pkg::OP_OTP_READ && idx_reg == 2'h1 |->
    ##1 wrStart && engData == flb_pkg::FC_READ_ARRAY)
    else $error("identifier mode not left with read array");
  a_otp_range: assert property (
    engStart && (op_reg == flb_pkg::OP_OTP_PROG || op_reg == flb_pkg::OP_OTP_LOCK) |-> rangeOk)
    else $error("protection write outside its address window");
  a_otp_data: assert property (
    wrStart && op_reg == flb_pkg::OP_OTP_PROG && idx_reg == 2'h1 |->
    engData == data_reg && $past(engData, 6) == flb_pkg::FC_OTP_SETUP)
    else $error("protection program data not sent after setup");
  a_otp_lock_value: assert property (
    wrStart && op_reg == flb_pkg::OP_OTP_LOCK && idx_reg == 2'h1 |->
    engData == flb_pkg::OTP_LOCK_VALUE)
    else $error("protection lock word value wrong");
  a_resume_clears: assert property (
    state_reg == SQ_START && op_reg == flb_pkg::OP_RESUME && step.kind == flb_pkg::SK_END |=>
    !suspended_reg)
    else $error("suspended flag kept after resume");

endmodule // flb_lock_ctrl

`default_nettype wire

// ==== flb_lock_ctrl_dummy_guard.sv ====
`default_nettype none
`default_nettype wire

// ==== flb_pkg.sv ====
// Purpose: Shared constants and carrier types for the flash lock controller.
// Assumes: 16-bit flash data bus, 22-bit word address, 25 MHz clock.
// Notes: Register offsets are byte addresses on the software port.
`default_nettype none

package flb_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and bus cycle timing.
  localparam int CLK_MHZ = 25;
  localparam int T_STROBE_NS = 60;
  localparam int T_READ_NS = 100;
  localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC = (T_READ_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  localparam logic [3:0] READ_CNT = 4'(READ_CYC);
  localparam logic [11:0] POLL_LIMIT = 12'hfff;

  ////////////////////////////////////////////////////////////////////////////////
  // Flash command codes.
  localparam logic [15:0] FC_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] FC_LOCK = 16'h0001;
  localparam logic [15:0] FC_UNLOCK = 16'h00d0;
  localparam logic [15:0] FC_LOCKDOWN = 16'h002f;
  localparam logic [15:0] FC_READ_IDENT = 16'h0090;
  localparam logic [15:0] FC_READ_ARRAY = 16'h00ff;
  localparam logic [15:0] FC_OTP_SETUP = 16'h00c0;
  localparam logic [15:0] FC_SUSPEND = 16'h00b0;
  localparam logic [15:0] FC_RESUME = 16'h00d0;
  localparam logic [15:0] FC_READ_STATUS = 16'h0070;
  localparam logic [15:0] FC_CLEAR_STATUS = 16'h0050;
  localparam logic [15:0] OTP_LOCK_VALUE = 16'hfffd;
  localparam logic [21:0] LOCK_STATUS_OFS = 22'h000002;

  // Status word bit positions.
  localparam int SW_READY = 7;
  localparam int SW_ERASE_SUSP = 6;
  localparam int SW_ERASE_ERR = 5;
  localparam int SW_PROG_ERR = 4;
  localparam int SW_SUPPLY_ERR = 3;
  localparam int SW_LOCK_ERR = 1;

  // Protection register word address window.
  localparam logic [21:0] OTP_FIRST = 22'h000080;
  localparam logic [21:0] OTP_LAST = 22'h000088;

  ////////////////////////////////////////////////////////////////////////////////
  // Software register map and fields.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PROTECT_HIGH = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Operation codes written to the command register.
  localparam logic [3:0] OP_LOCK = 4'h1;
  localparam logic [3:0] OP_UNLOCK = 4'h2;
  localparam logic [3:0] OP_LOCKDOWN = 4'h3;
  localparam logic [3:0] OP_LOCK_READ = 4'h4;
  localparam logic [3:0] OP_OTP_READ = 4'h5;
  localparam logic [3:0] OP_OTP_PROG = 4'h6;
  localparam logic [3:0] OP_OTP_LOCK = 4'h7;
  localparam logic [3:0] OP_SUSPEND = 4'h8;
  localparam logic [3:0] OP_RESUME = 4'h9;
  localparam logic [3:0] OP_STATUS = 4'ha;
  localparam logic [3:0] OP_CLEAR = 4'hb;
  localparam logic [3:0] OP_LAST = 4'hb;

  // Step kinds of an operation's script.
  localparam logic [1:0] SK_END = 2'h0;
  localparam logic [1:0] SK_WRITE = 2'h1;
  localparam logic [1:0] SK_READ = 2'h2;
  localparam logic [1:0] SK_POLL = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Carrier types.
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] dqOut;
    logic dqOe;
    logic ceN;
    logic weN;
    logic oeN;
  } flb_pins_type;

  typedef struct packed {
    logic [1:0] kind;
    logic addrPlus2;
    logic useData;
    logic [15:0] code;
  } flb_step_type;

endpackage : flb_pkg

`default_nettype wire

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the flash lock controller.
// Assumes: Flash model answers every cycle at once.
// Notes: Each scenario task drives and judges on its own.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, flashRstN, flashProtectN;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0, regRdData, r;
  logic [15:0] flashDqIn;
  flb_pkg::flb_pins_type flashPins;
  int n_fail = 0, cmp_count = 0;
  flb_lock_ctrl uut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .flashPins(flashPins),
    .flashDqIn(flashDqIn), .flashRstN(flashRstN), .flashProtectN(flashProtectN));
  flb_flash_model dev (.clk(clk), .pins(flashPins), .rstN(flashRstN),
    .protectN(flashProtectN), .dqIn(flashDqIn));
  initial
  begin
    forever #20 clk = ~clk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdData;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic op(input logic [3:0] o, input logic [21:0] a, input logic [15:0] v);
    logic [31:0] s;
    wr(flb_pkg::REG_ADDR, {10'h0, a});
    wr(flb_pkg::REG_DATA, {16'h0, v});
    wr(flb_pkg::REG_CMD, {28'h0, o});
    s = 32'h1;
    for (int i = 0; i < 200 && s[0] !== 1'b0; i++)
      rd(flb_pkg::REG_STATUS, s);
    chk(s & 32'h1, 32'h0);
  endtask
  // Runs one lock operation on a block (none for code 0), then reads its two lock bits back.
  task automatic lock_chk(input logic [3:0] o, input logic [21:0] a, input logic [31:0] e);
    if (o != 4'h0)
      op(o, a, 16'h0);
    op(flb_pkg::OP_LOCK_READ, a, 16'h0);
    rd(flb_pkg::REG_RESULT, r);
    chk(r, e);
  endtask
  task automatic t_lock_states;
    lock_chk(4'h0, 22'h010000, 32'h1);
    lock_chk(flb_pkg::OP_UNLOCK, 22'h010000, 32'h0);
    lock_chk(flb_pkg::OP_LOCK, 22'h010000, 32'h1);
    lock_chk(flb_pkg::OP_LOCKDOWN, 22'h010000, 32'h3);
    lock_chk(flb_pkg::OP_UNLOCK, 22'h010000, 32'h3);
    wr(flb_pkg::REG_CTRL, 32'h3);
    lock_chk(flb_pkg::OP_UNLOCK, 22'h010000, 32'h2);
    wr(flb_pkg::REG_CTRL, 32'h1);
    lock_chk(4'h0, 22'h010000, 32'h3);
    wr(flb_pkg::REG_CTRL, 32'h0);
    wr(flb_pkg::REG_CTRL, 32'h1);
    lock_chk(4'h0, 22'h010000, 32'h1);
  endtask
  task automatic t_suspend;
    op(flb_pkg::OP_SUSPEND, 22'h020000, 16'h0);
    rd(flb_pkg::REG_STATUS, r);
    chk({31'h0, r[3]}, 32'h1);
    lock_chk(flb_pkg::OP_UNLOCK, 22'h020000, 32'h0);
    op(flb_pkg::OP_RESUME, 22'h020000, 16'h0);
    rd(flb_pkg::REG_STATUS, r);
    chk({31'h0, r[3]}, 32'h0);
  endtask
  task automatic t_otp;
    op(flb_pkg::OP_OTP_PROG, 22'h000084, 16'h1234);
    rd(flb_pkg::REG_STATUS, r);
    chk({31'h0, r[5]}, 32'h0);
    chk({31'h0, r[6]}, 32'h0);
    op(flb_pkg::OP_OTP_LOCK, flb_pkg::OTP_FIRST, 16'h0);
    op(flb_pkg::OP_OTP_PROG, 22'h000084, 16'h0000);
    rd(flb_pkg::REG_STATUS, r);
    chk({31'h0, r[5]}, 32'h1);
    op(flb_pkg::OP_OTP_READ, flb_pkg::OTP_FIRST, 16'h0);
    rd(flb_pkg::REG_RESULT, r);
    chk(r & 32'hffff, 32'hfffc);
  endtask
  task automatic t_refused;
    wr(flb_pkg::REG_ADDR, 32'h100);
    wr(flb_pkg::REG_CMD, {28'h0, flb_pkg::OP_OTP_PROG});
    rd(flb_pkg::REG_STATUS, r);
    chk({31'h0, r[1]}, 32'h1);
    rd(8'h20, r);
    chk(r, 32'h0);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // The span allows one poll loop to run out once, with less than its own length to spare.
  initial
  begin
    #2000000;
    n_fail++;
    give_verdict;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    wr(flb_pkg::REG_CTRL, 32'h1);
    t_lock_states;
    t_suspend;
    t_otp;
    t_refused;
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
